// ---- pkg/tgcc_pkg.sv ----
// Constants shared by the timer gate count control block
package tgcc_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 16;
    localparam int SYNC_STAGES = 2;
    localparam int WDT_BASE_CYC = 16;

    // ***************************************************
    // Register offsets
    // ***************************************************
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_COUNT_L = 3'h1;
    localparam logic [2:0] OFS_COUNT_H = 3'h2;
    localparam logic [2:0] OFS_OPT = 3'h3;
    localparam logic [2:0] OFS_T0 = 3'h4;
    localparam logic [2:0] OFS_T2 = 3'h5;
    localparam logic [2:0] OFS_T2_PER = 3'h6;

    // ***************************************************
    // Field positions and reset values
    // ***************************************************
    localparam int CTRL_ON = 0;
    localparam int CTRL_GE = 1;
    localparam int CTRL_POL = 2;
    localparam int CTRL_TGL = 3;
    localparam int CTRL_GSS = 4;
    localparam int CTRL_GACT = 6;
    localparam int OPT_RATIO = 0;
    localparam int OPT_PREASSIGN = 3;
    localparam int OPT_WDTE = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OPT_RST = 8'h0F;
    localparam logic [7:0] T2_PER_RST = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // ***************************************************
    // Gate source codes
    // ***************************************************
    localparam logic [1:0] GSS_PIN = 2'h0;
    localparam logic [1:0] GSS_T0 = 2'h1;
    localparam logic [1:0] GSS_T2 = 2'h2;
    localparam logic [1:0] GSS_WDT = 2'h3;
endpackage

// ---- pkg/tgcc_wdt_if.sv ----
// Link between the gate control and the watchdog interval counter
`timescale 1ns/1ps
interface tgcc_wdt_if;
    logic run;
    logic clear;
    logic assign_pre;
    logic [2:0] ratio;
    logic reset_enable;
    logic overflow;
    logic reset_req;

    modport ctl (output run, output clear, output assign_pre, output ratio, output reset_enable,
                 input overflow, input reset_req);
    modport wdt (input run, input clear, input assign_pre, input ratio, input reset_enable,
                 output overflow, output reset_req);
endinterface

// ---- tb/tgcc_partner.sv ----
// Far-side model: timer clock source bursts and neighbouring timer increment pulses
`timescale 1ns/1ps
module tgcc_partner
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic src_run,
    input wire logic tick_en,
    output logic timer_clock_source,
    output logic t0_tick,
    output logic t2_tick
);
    logic [2:0] phase_r;
    logic tick_r;

    // ***************************************************
    // Source: three cycles high, three low, still outside a burst
    // ***************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            phase_r <= 3'h0;
        else if (!src_run || phase_r == 3'h5)
            phase_r <= 3'h0;
        else
            phase_r <= phase_r + 3'h1;
    end

    assign timer_clock_source = src_run && (phase_r < 3'h3);

    // ***************************************************
    // Increment pulses on alternate cycles
    // ***************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tick_r <= 1'b0;
        else
            tick_r <= ~tick_r;
    end

    assign t0_tick = tick_en & tick_r;
    assign t2_tick = tick_en & ~tick_r;
endmodule // tgcc_partner

// ---- tb/timer1_gate_count_control_tb.sv ----
// Self-checking bench for the timer gate count control block
`timescale 1ns/1ps
module timer1_gate_count_control_tb;
    import tgcc_pkg::*;
    localparam int WB = 4;
    // Gate bit reads set after reset: pin low matches polarity 0
    localparam logic [7:0] RST_TAB [8] = '{8'h40, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'hFF, 8'h00};
    localparam logic [7:0] WOPT [4] = '{8'h03, 8'h08, 8'h09, 8'h0A};
    localparam logic [15:0] WPER [4] = '{16'h0004, 16'h0004, 16'h0008, 16'h0010};
    logic clk, rst_b, wr, rd, gate_input_pin, wdt_clear, src_run, tick_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rv, m_t0, m_t2, per2, ctl;
    logic [COUNT_W-1:0] counter_value;
    logic gate_active, t0_overflow, t2_match, wdt_osc_on, wdt_reset_req;
    logic timer_clock_source, t0_tick, t2_tick, p0, p2, pulse_chk, lvl;
    logic [1:0] gss;
    logic [31:0] seed;
    int fail_count, checks, rr_cnt, gap, n, exp_cnt;

    tgcc_top #(.WDT_BASE(WB)) u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .gate_input_pin(gate_input_pin), .timer_clock_source(timer_clock_source),
        .t0_tick(t0_tick), .t2_tick(t2_tick), .wdt_clear(wdt_clear), .counter_value(counter_value),
        .gate_active(gate_active), .t0_overflow(t0_overflow), .t2_match(t2_match),
        .wdt_osc_on(wdt_osc_on), .wdt_reset_req(wdt_reset_req));
    tgcc_partner u_far (.clk(clk), .rst_b(rst_b), .src_run(src_run), .tick_en(tick_en),
        .timer_clock_source(timer_clock_source), .t0_tick(t0_tick), .t2_tick(t2_tick));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ***************************************************
    // Shared tasks
    // ***************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic burst(input int k);
        @(posedge clk);
        src_run <= 1'b1;
        repeat (6 * k) @(posedge clk);
        src_run <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic wait_tog(output int g);
        logic prev;
        prev = gate_active;
        g = 0;
        do
        begin
            @(posedge clk);
            #1 g++;
        end
        while (gate_active === prev && g < 300);
    endtask

    task automatic end_of_test;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ***************************************************
    // Neighbouring timer model and pulse monitor
    // ***************************************************
    always @(posedge clk)
    begin
        if (pulse_chk)
        begin
            chk(t0_overflow, p0);
            chk(t2_match, p2);
        end
        p0 = t0_tick && m_t0 == 8'hFF;
        p2 = t2_tick && m_t2 == per2;
        if (t0_tick) m_t0 = m_t0 + 8'h01;
        if (t2_tick) m_t2 = p2 ? 8'h00 : m_t2 + 8'h01;
        if (wdt_reset_req) rr_cnt++;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test;
    end

    // ***************************************************
    // Main sequence
    // ***************************************************
    initial
    begin
        rst_b = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0; gate_input_pin = 1'b0;
        wdt_clear = 1'b0; src_run = 1'b0; tick_en = 1'b0; pulse_chk = 1'b0; p0 = 1'b0; p2 = 1'b0;
        seed = 32'h6C0C; fail_count = 0; checks = 0; rr_cnt = 0; exp_cnt = 0;
        m_t0 = 8'h00; m_t2 = 8'h00; per2 = 8'hFF;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rd_reg(i[2:0], rv);
            chk(rv, RST_TAB[i]);
        end
        // Read-only gate bit, reserved bits and unmapped index
        wr_reg(OFS_CTRL, 8'hC3);
        rd_reg(OFS_CTRL, rv);
        chk(rv, 8'h43);
        wr_reg(OFS_OPT, 8'hE0);
        rd_reg(OFS_OPT, rv);
        chk(rv, 8'h00);
        wr_reg(3'h7, 8'hFF);
        rd_reg(3'h7, rv);
        chk(rv, 8'h00);
        // Random gate settings against counted source edges
        for (int i = 0; i < 18; i++)
        begin
            seed = lfsr(seed);
            gss = 2'(i % 3);
            ctl = {2'b00, gss, 1'b0, seed[2:0]};
            n = 1 + int'(seed[10:9]);
            @(posedge clk);
            gate_input_pin <= seed[8];
            wr_reg(OFS_CTRL, ctl);
            repeat (4) @(posedge clk);
            burst(n);
            lvl = (gss == GSS_PIN) ? seed[8] : 1'b0;
            if (ctl[CTRL_ON] && (!ctl[CTRL_GE] || lvl == ctl[CTRL_POL]))
                exp_cnt = exp_cnt + n;
            chk(counter_value, exp_cnt[15:0]);
        end
        rd_reg(OFS_COUNT_L, rv);
        chk(rv, exp_cnt[7:0]);
        rd_reg(OFS_COUNT_H, rv);
        chk(rv, exp_cnt[15:8]);
        // Eight-bit rollover and second timer period match
        wr_reg(OFS_CTRL, 8'h00);
        wr_reg(OFS_T0, 8'hFA);
        m_t0 = 8'hFA;
        wr_reg(OFS_T2_PER, 8'h03);
        per2 = 8'h03;
        wr_reg(OFS_T2, 8'h00);
        m_t2 = 8'h00;
        pulse_chk = 1'b1;
        @(posedge clk);
        tick_en <= 1'b1;
        repeat (41) @(posedge clk);
        tick_en <= 1'b0;
        repeat (3) @(posedge clk);
        pulse_chk = 1'b0;
        rd_reg(OFS_T0, rv);
        chk(rv, m_t0);
        rd_reg(OFS_T2, rv);
        chk(rv, m_t2);
        // Watchdog as gate source
        wr_reg(OFS_CTRL, 8'h32);
        #1 chk(wdt_osc_on, 1'b1);
        wr_reg(OFS_CTRL, 8'h30);
        #1 chk(wdt_osc_on, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(OFS_CTRL, 8'h00);
            wr_reg(OFS_OPT, WOPT[i]);
            wr_reg(OFS_CTRL, 8'h3F);
            wait_tog(gap);
            wait_tog(gap);
            chk(gap[15:0], WPER[i]);
        end
        wait_tog(gap);
        repeat (3) @(posedge clk);
        wdt_clear <= 1'b1;
        @(posedge clk);
        wdt_clear <= 1'b0;
        wait_tog(gap);
        chk(gap > 13, 1'b1);
        chk(rr_cnt[15:0], 16'h0000);
        wr_reg(OFS_CTRL, 8'h00);
        wr_reg(OFS_OPT, 8'h10);
        repeat (60) @(posedge clk);
        chk(rr_cnt > 0, 1'b1);
        end_of_test;
    end
endmodule // timer1_gate_count_control_tb

// ---- verilog/tgcc_sync.sv ----
// Two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module tgcc_sync
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    if (W < 1)
    begin : g_chk
        $error("tgcc_sync needs W of at least 1");
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // tgcc_sync

// ---- verilog/tgcc_top.sv ----
// Timer counter with gate count control and its gate sources
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module tgcc_top
#(
    parameter int WDT_BASE = tgcc_pkg::WDT_BASE_CYC
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [tgcc_pkg::ADDR_W-1:0] addr,
    input wire logic [tgcc_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [tgcc_pkg::DATA_W-1:0] rdata,
    input wire logic gate_input_pin,
    input wire logic timer_clock_source,
    input wire logic t0_tick,
    input wire logic t2_tick,
    input wire logic wdt_clear,
    output logic [tgcc_pkg::COUNT_W-1:0] counter_value,
    output logic gate_active,
    output logic t0_overflow,
    output logic t2_match,
    output logic wdt_osc_on,
    output logic wdt_reset_req
);
    import tgcc_pkg::*;

    // ***************************************************
    // Declarations
    // ***************************************************
    logic [7:0] ctrl_r;
    logic [7:0] opt_r;
    logic [15:0] count_r;
    logic [7:0] t0_r;
    logic [7:0] t2_r;
    logic [7:0] t2_per_r;
    logic [7:0] rdata_r;
    logic [7:0] rd_nxt;
    logic t0_ovf_r;
    logic t2_match_r;
    logic wdt_ovf_r;
    logic clk_src_prev_r;
    logic gate_prev_r;
    logic toggle_r;
    logic [1:0] sync_q;
    logic pin_s;
    logic clk_src_s;
    logic src_edge;
    logic counter_on;
    logic gate_count_enable;
    logic gate_polarity_select;
    logic gate_toggle;
    logic [1:0] gate_source_select;
    logic gate_level;
    logic gate_match;
    logic gate_ok;

    tgcc_wdt_if wif ();

    function automatic logic [7:0] inc8(input logic [7:0] v);
        return v + 8'h01;
    endfunction

    // ***************************************************
    // Control fields
    // ***************************************************
    assign counter_on = ctrl_r[CTRL_ON];
    assign gate_count_enable = ctrl_r[CTRL_GE];
    assign gate_polarity_select = ctrl_r[CTRL_POL];
    assign gate_toggle = ctrl_r[CTRL_TGL];
    assign gate_source_select = ctrl_r[CTRL_GSS +: 2];

    // ***************************************************
    // Register writes
    // ***************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_r <= CTRL_RST;
            opt_r <= OPT_RST;
            t2_per_r <= T2_PER_RST;
        end
        else if (wr)
        begin
            if (addr == OFS_CTRL)
            begin
                ctrl_r <= {2'h0, wdata[5:0]};
            end
            if (addr == OFS_OPT)
            begin
                opt_r <= {3'h0, wdata[4:0]};
            end
            if (addr == OFS_T2_PER)
            begin
                t2_per_r <= wdata;
            end
        end
    end

    // ***************************************************
    // Input synchronisation
    // ***************************************************
    tgcc_sync #(.W(2)) u_sync
    (
        .clk(clk),
        .rst_b(rst_b),
        .d({timer_clock_source, gate_input_pin}),
        .q(sync_q)
    );

    assign pin_s = sync_q[0];
    assign clk_src_s = sync_q[1];

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clk_src_prev_r <= 1'b0;
        end
        else
        begin
            clk_src_prev_r <= clk_src_s;
        end
    end

    assign src_edge = clk_src_s && !clk_src_prev_r;

    // ***************************************************
    // Eight-bit timer
    // ***************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            t0_r <= BYTE_ZERO;
            t0_ovf_r <= 1'b0;
        end
        else
        begin
            t0_ovf_r <= t0_tick && (t0_r == BYTE_MAX);
            if (wr && addr == OFS_T0)
            begin
                t0_r <= wdata;
            end
            else if (t0_tick)
            begin
                t0_r <= inc8(t0_r);
            end
        end
    end

    // ***************************************************
    // Second timer with period match
    // ***************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            t2_r <= BYTE_ZERO;
            t2_match_r <= 1'b0;
        end
        else
        begin
            t2_match_r <= t2_tick && (t2_r == t2_per_r);
            if (wr && addr == OFS_T2)
            begin
                t2_r <= wdata;
            end
            else if (t2_tick)
            begin
                t2_r <= (t2_r == t2_per_r) ? BYTE_ZERO : inc8(t2_r);
            end
        end
    end

    // ***************************************************
    // Watchdog counter
    // ***************************************************
    assign wif.run = opt_r[OPT_WDTE] || (gate_count_enable && gate_source_select == GSS_WDT);
    assign wif.clear = wdt_clear;
    assign wif.assign_pre = opt_r[OPT_PREASSIGN];
    assign wif.ratio = opt_r[OPT_RATIO +: 3];
    assign wif.reset_enable = opt_r[OPT_WDTE];

    tgcc_wdt #(.BASE(WDT_BASE)) u_wdt
    (
        .clk(clk),
        .rst_b(rst_b),
        .w(wif.wdt)
    );

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wdt_ovf_r <= 1'b0;
        end
        else
        begin
            wdt_ovf_r <= wif.overflow;
        end
    end

    // ***************************************************
    // Gate source selection and polarity
    // ***************************************************
    always_comb
    begin
        case (gate_source_select)
            GSS_PIN: gate_level = pin_s;
            GSS_T0: gate_level = t0_ovf_r;
            GSS_T2: gate_level = t2_match_r;
            GSS_WDT: gate_level = wdt_ovf_r;
            default: gate_level = 1'b0;
        endcase
    end

    assign gate_match = (gate_level == gate_polarity_select);

    // Toggle mode flips the gate on each rise of the matched level
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gate_prev_r <= 1'b0;
            toggle_r <= 1'b0;
        end
        else
        begin
            gate_prev_r <= gate_match;
            if (!gate_toggle || !gate_count_enable)
            begin
                toggle_r <= 1'b0;
            end
            else if (gate_match && !gate_prev_r)
            begin
                toggle_r <= !toggle_r;
            end
        end
    end

    assign gate_ok = gate_toggle ? toggle_r : gate_match;

    // ***************************************************
    // Main counter
    // ***************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_r <= COUNT_RST;
        end
        else if (wr && addr == OFS_COUNT_L)
        begin
            count_r[7:0] <= wdata;
        end
        else if (wr && addr == OFS_COUNT_H)
        begin
            count_r[15:8] <= wdata;
        end
        else if (counter_on && src_edge && (!gate_count_enable || gate_ok))
        begin
            count_r <= count_r + 16'h0001;
        end
    end

    // ***************************************************
    // Register reads
    // ***************************************************
    always_comb
    begin
        case (addr)
            OFS_CTRL: rd_nxt = {1'b0, gate_ok, ctrl_r[5:0]};
            OFS_COUNT_L: rd_nxt = count_r[7:0];
            OFS_COUNT_H: rd_nxt = count_r[15:8];
            OFS_OPT: rd_nxt = opt_r;
            OFS_T0: rd_nxt = t0_r;
            OFS_T2: rd_nxt = t2_r;
            OFS_T2_PER: rd_nxt = t2_per_r;
            default: rd_nxt = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_r <= BYTE_ZERO;
        end
        else
        begin
            rdata_r <= rd ? rd_nxt : BYTE_ZERO;
        end
    end

    assign rdata = rdata_r;
    assign counter_value = count_r;
    assign gate_active = gate_ok;
    assign t0_overflow = t0_ovf_r;
    assign t2_match = t2_match_r;
    assign wdt_osc_on = wif.run;
    assign wdt_reset_req = wif.reset_req;

    // ***************************************************
    // Assertions
    // ***************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_off_holds: assert property (!counter_on && !wr |=> $stable(count_r))
        else $error("counter moved while switched off");
    a_free_count: assert property (counter_on && !gate_count_enable && src_edge && !wr
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("free running counter missed an edge");
    a_gated_count: assert property (counter_on && gate_count_enable && gate_ok && src_edge && !wr
        |=> count_r == $past(count_r) + 16'h0001)
        else $error("active gate did not count");
    a_gate_hold: assert property (gate_count_enable && !gate_ok && !wr |=> $stable(count_r))
        else $error("inactive gate changed the count");
    a_pin_polarity: assert property (!gate_toggle && gate_source_select == GSS_PIN
        |-> gate_ok == (pin_s == gate_polarity_select))
        else $error("pin gate polarity wrong");
    a_t0_pulse: assert property (t0_tick && t0_r == BYTE_MAX && !wr
        |=> t0_ovf_r && t0_r == BYTE_ZERO ##1 !t0_ovf_r || t0_tick)
        else $error("rollover pulse wrong");
    a_t2_clear: assert property (t2_tick && t2_r == t2_per_r && !wr
        |=> t2_r == BYTE_ZERO && t2_match_r)
        else $error("period match did not clear");
    a_wdt_run: assert property (gate_count_enable && gate_source_select == GSS_WDT |-> wif.run)
        else $error("watchdog not forced on");
    a_no_reset: assert property (wdt_reset_req |-> opt_r[OPT_WDTE])
        else $error("reset without watchdog enable");
    a_clear_restart: assert property (wdt_clear |=> !wif.overflow [*2])
        else $error("clear did not restart interval");
    a_pin_sync: assert property (##2 pin_s == $past(gate_input_pin, 2))
        else $error("gate pin not two stages late");
    a_src_select: assert property (gate_source_select == GSS_T2 && !gate_toggle
        |-> gate_match == (t2_match_r == gate_polarity_select))
        else $error("gate source select wrong");

    c_gated_count: cover property (counter_on && gate_count_enable && gate_ok && src_edge);
    c_wdt_gate: cover property (gate_source_select == GSS_WDT && wdt_ovf_r);
    c_t2_match: cover property (t2_match_r);
    c_toggle: cover property (gate_toggle && $rose(toggle_r));
endmodule // tgcc_top

// ---- verilog/tgcc_wdt.sv ----
// Watchdog interval counter with prescaler, usable as a gate source
`timescale 1ns/1ps
module tgcc_wdt
#(
    parameter int BASE = tgcc_pkg::WDT_BASE_CYC
)
(
    input wire logic clk,
    input wire logic rst_b,
    tgcc_wdt_if.wdt w
);
    import tgcc_pkg::*;

    logic [7:0] pre_r;
    logic [15:0] base_r;
    logic [7:0] pre_mask;
    logic pre_tick;
    logic ovf_r;

    if (BASE < 2 || BASE > 65535)
    begin : g_chk
        $error("tgcc_wdt BASE must lie in 2..65535");
    end

    // Prescaler divides by two to the ratio when assigned to the watchdog
    assign pre_mask = ~(BYTE_MAX << w.ratio);
    assign pre_tick = !w.assign_pre || (pre_r == pre_mask);

    // ***************************************************
    // Interval counter
    // ***************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_r <= BYTE_ZERO;
            base_r <= COUNT_RST;
            ovf_r <= 1'b0;
        end
        else if (!w.run || w.clear)
        begin
            pre_r <= BYTE_ZERO;
            base_r <= COUNT_RST;
            ovf_r <= 1'b0;
        end
        else
        begin
            ovf_r <= 1'b0;
            pre_r <= pre_tick ? BYTE_ZERO : pre_r + 8'h01;
            if (pre_tick)
            begin
                if (base_r == 16'(BASE - 1))
                begin
                    base_r <= COUNT_RST;
                    ovf_r <= 1'b1;
                end
                else
                begin
                    base_r <= base_r + 16'h0001;
                end
            end
        end
    end

    assign w.overflow = ovf_r;
    // Gate use alone never raises a reset request
    assign w.reset_req = ovf_r && w.reset_enable;
endmodule // tgcc_wdt
